// File: hw/lrc_pkg.sv
/*
  shared constants and carrier types for the lcd driver reset/config block.
  assumes a decoded command byte stream from an upstream serial decoder.
*/
package lrc_pkg;
  // command selectors presented by the upstream decoder
  localparam logic [3:0] LRC_CMD_NONE = 4'h0;
  localparam logic [3:0] LRC_CMD_BL_POL = 4'h1;
  localparam logic [3:0] LRC_CMD_MODE = 4'h2;
  localparam logic [3:0] LRC_CMD_CLK = 4'h3;
  localparam logic [3:0] LRC_CMD_AUX_CFG = 4'h4;
  localparam logic [3:0] LRC_CMD_BP_CNT = 4'h5;
  localparam logic [3:0] LRC_CMD_RATIO = 4'h6;
  localparam logic [3:0] LRC_CMD_LCD_RATE = 4'h7;
  localparam logic [3:0] LRC_CMD_BL_RATE = 4'h8;
  localparam logic [3:0] LRC_CMD_AUX_LVL = 4'h9;
  localparam logic [3:0] LRC_CMD_SEG_PTR = 4'hA;
  localparam logic [3:0] LRC_CMD_BL_PTR = 4'hB;
  localparam logic [3:0] LRC_CMD_INIT = 4'hC;
  localparam logic [3:0] LRC_CMD_RAM_WR = 4'hD;
  // field positions inside the command byte
  localparam int LRC_MODE_EN_POS = 0;
  localparam int LRC_MODE_PD_POS = 1;
  localparam int LRC_MODE_INV_POS = 2;
  localparam int LRC_MODE_BPS_POS = 3;
  localparam int LRC_AUX_GRP_POS = 4;
  // reset values
  localparam logic [4:0] LRC_LCD_RATE_RST = 5'h0E;
  localparam logic [3:0] LRC_BL_RATE_RST = 4'h7;
  localparam logic [1:0] LRC_MUX_RST = 2'h0;
  localparam logic [1:0] LRC_BIAS_RST = 2'h0;
  // backplane count codes and pointer limits
  localparam logic [1:0] LRC_MUX_8 = 2'h0;
  localparam logic [1:0] LRC_MUX_6 = 2'h1;
  localparam logic [1:0] LRC_MUX_4 = 2'h2;
  localparam logic [5:0] LRC_SEG_8 = 6'h28;
  localparam logic [5:0] LRC_SEG_6 = 6'h2A;
  localparam logic [5:0] LRC_SEG_4 = 6'h2C;
  localparam logic [5:0] LRC_AUX_PINS = 6'h06;
  localparam logic [2:0] LRC_BL_CH = 3'h6;
  localparam int LRC_RAM_DEPTH = 44;

  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] data;
    logic valid;
  } lrc_cmd_t;

  typedef struct packed {
    logic backlight_invert;
    logic bias_supply_sel;
    logic frame_polarity_alt;
    logic power_down;
    logic display_en;
    logic ext_frame_ref;
    logic clock_out_drive;
    logic clock_source_sel;
    logic [11:0] aux_out_cfg;
    logic [1:0] mux;
    logic [1:0] bias;
    logic [4:0] lcd_rate_div;
    logic [3:0] backlight_rate_div;
    logic [5:0] aux_static_level;
    logic [5:0] seg_ram_ptr;
    logic seg_ptr_ok;
    logic [2:0] backlight_ptr;
    logic bl_ptr_ok;
  } lrc_cfg_t;

  typedef enum logic [1:0] {
    LRC_ST_RESET = 2'b00,
    LRC_ST_WAIT_INIT = 2'b01,
    LRC_ST_RUN = 2'b10
  } lrc_state_t;
endpackage

// File: hw/lrc_top.sv
/*
  configuration register file and reset handling of the lcd driver.
  assumes commands arrive already decoded, one per cycle, synchronous
  to sys_clk (the internal oscillator clock).
*/
`timescale 1ns/10ps
// Notes on behaviour
// R1: reset clears fields, dividers load defaults
// R2: host sends initialize command first
// R3: host fills ram before display on
// R4: reset pin restores every configuration register
// R5: pin reset leaves display ram intact
// R6: after release, behave as power-on
// R7: host order: power, modes, ram, display
// R8: four, six or eight backplanes, 44 segments
// R9: 40/42/44 segments without aux outputs
// R10: six aux outputs take six segments
// R11: reset state: display off, outputs grounded
// R12: ram not initialised at power-on
// R13: reset asserts async, releases on clock
module lrc_top
  import lrc_pkg::*;
(
  input wire logic sys_clk, // oscillator clock, 100 MHz
  input wire logic resetn, // async reset pin, active low
  input wire logic clk_en, // freezes all state except the reset synchroniser when low
  input wire lrc_pkg::lrc_cmd_t cmd, // decoded command from host
  output lrc_pkg::lrc_cfg_t cfg, // live configuration
  output logic [5:0] seg_count, // usable segment outputs
  output logic [7:0] ram_rd_data, // ram word at segment pointer
  output logic init_seen, // initialize command received
  output logic outputs_grounded // backplanes and segments at ground
);
  import lrc_pkg::*;

  typedef struct packed {
    lrc_state_t st;
    lrc_cfg_t cfg;
    logic [5:0] seg_count;
    logic [7:0] ram_rd;
    logic init_seen;
    logic grounded;
  } lrc_state_all_t;

  lrc_state_all_t s_q; // all registered state except the ram and reset synchroniser
  lrc_state_all_t s_d; // next state
  logic rst_n_int; // internal synchronised reset
  logic [7:0] ram_q [LRC_RAM_DEPTH]; // display ram, no reset
  logic [5:0] seg_max; // segment limit for backplane count
  logic [5:0] aux_used; // pins taken by aux outputs
  logic ram_we; // ram write strobe

  // reset synchroniser: async assert, sync release
  logic [1:0] rsync_q; // synchroniser chain
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rsync_q <= 2'h0; // R13
    else
      rsync_q <= {rsync_q[0], 1'b1}; // R13
  end
  assign rst_n_int = rsync_q[1];

  // segment limit from backplane count
  always_comb
  begin
    case (s_q.cfg.mux)
      LRC_MUX_6: seg_max = LRC_SEG_6; // R9
      LRC_MUX_4: seg_max = LRC_SEG_4; // R9
      default: seg_max = LRC_SEG_8; // R8
    endcase
    // any enabled aux pin takes its segment pin (R10 full case: six)
    aux_used = 6'h00;
    for (int i = 0; i < 6; i++)
      if (s_q.cfg.aux_out_cfg[2*i +: 2] != 2'h0)
        aux_used = aux_used + 6'h01; // R10
  end

  // next-state logic for configuration and sequencing
  always_comb
  begin
    s_d = s_q;
    if (clk_en)
    begin
      s_d.seg_count = seg_max - aux_used; // R9 R10
      s_d.ram_rd = ram_q[s_q.cfg.seg_ram_ptr];
      // display stays grounded until enabled and powered
      s_d.grounded = !s_q.cfg.display_en || s_q.cfg.power_down; // R11
      case (s_q.st)
        LRC_ST_RESET: s_d.st = LRC_ST_WAIT_INIT; // R6
        LRC_ST_WAIT_INIT:
        begin
          // device still accepts commands; host must send init first
          if (cmd.valid && cmd.sel == LRC_CMD_INIT)
          begin
            s_d.st = LRC_ST_RUN;
            s_d.init_seen = 1'b1;
          end
        end
        LRC_ST_RUN: s_d.st = LRC_ST_RUN;
        default: s_d.st = LRC_ST_RESET;
      endcase
      if (cmd.valid && s_q.st != LRC_ST_RESET)
      begin
        case (cmd.sel)
          LRC_CMD_BL_POL: s_d.cfg.backlight_invert = cmd.data[0];
          LRC_CMD_MODE:
          begin
            s_d.cfg.display_en = cmd.data[LRC_MODE_EN_POS];
            s_d.cfg.power_down = cmd.data[LRC_MODE_PD_POS];
            s_d.cfg.frame_polarity_alt = cmd.data[LRC_MODE_INV_POS];
            s_d.cfg.bias_supply_sel = cmd.data[LRC_MODE_BPS_POS];
          end
          LRC_CMD_CLK:
          begin
            s_d.cfg.clock_source_sel = cmd.data[0];
            s_d.cfg.clock_out_drive = cmd.data[1];
            s_d.cfg.ext_frame_ref = cmd.data[2];
          end
          LRC_CMD_AUX_CFG:
          begin
            // group select picks pairs 0-1, 2-3 or 4-5
            case (cmd.data[LRC_AUX_GRP_POS +: 2])
              2'h0: s_d.cfg.aux_out_cfg[3:0] = cmd.data[3:0];
              2'h1: s_d.cfg.aux_out_cfg[7:4] = cmd.data[3:0];
              2'h2: s_d.cfg.aux_out_cfg[11:8] = cmd.data[3:0];
              default: ; // ignored group code
            endcase
          end
          LRC_CMD_BP_CNT:
            if (cmd.data[1:0] != 2'h3)
              s_d.cfg.mux = cmd.data[1:0]; // R8
          LRC_CMD_RATIO: s_d.cfg.bias = cmd.data[1:0];
          LRC_CMD_LCD_RATE: s_d.cfg.lcd_rate_div = cmd.data[4:0];
          LRC_CMD_BL_RATE: s_d.cfg.backlight_rate_div = cmd.data[3:0];
          LRC_CMD_AUX_LVL:
            if (cmd.data[3])
              s_d.cfg.aux_static_level[5:3] = cmd.data[2:0];
            else
              s_d.cfg.aux_static_level[2:0] = cmd.data[2:0];
          LRC_CMD_SEG_PTR:
          begin
            // out-of-range pointer blocks ram writes until fixed
            s_d.cfg.seg_ram_ptr = cmd.data[5:0];
            s_d.cfg.seg_ptr_ok = cmd.data[5:0] < seg_max; // R8
          end
          LRC_CMD_BL_PTR:
          begin
            s_d.cfg.backlight_ptr = cmd.data[2:0];
            s_d.cfg.bl_ptr_ok = cmd.data[2:0] < LRC_BL_CH;
          end
          LRC_CMD_RAM_WR:
            if (s_q.cfg.seg_ptr_ok)
              s_d.cfg.seg_ram_ptr = (s_q.cfg.seg_ram_ptr + 6'h01 >= seg_max)
                ? 6'h00 : s_q.cfg.seg_ram_ptr + 6'h01;
          default: ; // other commands belong elsewhere
        endcase
      end
    end
  end

  assign ram_we = clk_en && cmd.valid && cmd.sel == LRC_CMD_RAM_WR &&
    s_q.cfg.seg_ptr_ok && s_q.st != LRC_ST_RESET;

  // state register: all config returns to defaults on reset
  always_ff @(posedge sys_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      s_q <= '0; // R1 R4 R11
      s_q.st <= LRC_ST_RESET; // R6
      s_q.cfg.lcd_rate_div <= LRC_LCD_RATE_RST; // R1
      s_q.cfg.backlight_rate_div <= LRC_BL_RATE_RST; // R1
      s_q.cfg.mux <= LRC_MUX_RST; // R11
      s_q.cfg.bias <= LRC_BIAS_RST; // R11
      s_q.cfg.seg_ptr_ok <= 1'b1;
      s_q.cfg.bl_ptr_ok <= 1'b1;
      s_q.seg_count <= LRC_SEG_8;
      s_q.grounded <= 1'b1; // R11
    end
    else
      s_q <= s_d;
  end

  // display ram: no reset, survives pin reset, random at power-on
  always_ff @(posedge sys_clk)
  begin
    if (ram_we)
      ram_q[s_q.cfg.seg_ram_ptr] <= cmd.data; // R5 R12
  end

  assign cfg = s_q.cfg;
  assign seg_count = s_q.seg_count;
  assign ram_rd_data = s_q.ram_rd;
  assign init_seen = s_q.init_seen;
  assign outputs_grounded = s_q.grounded;

  // assertions
  property p_defaults;
    @(posedge sys_clk) $rose(rst_n_int) |->
      cfg.lcd_rate_div == LRC_LCD_RATE_RST &&
      cfg.backlight_rate_div == LRC_BL_RATE_RST &&
      cfg.seg_ram_ptr == 6'h00 && cfg.backlight_ptr == 3'h0;
  endproperty
  a_defaults: assert property (p_defaults) // R1
    else $error("reset defaults wrong");

  property p_pin_reset;
    @(posedge sys_clk) !rst_n_int |-> !cfg.display_en && cfg.mux == 2'h0
      && cfg.aux_out_cfg == 12'h000;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // R4
    else $error("config not at default in reset");

  property p_grounded;
    @(posedge sys_clk) disable iff (!rst_n_int)
      clk_en && !cfg.display_en |=> outputs_grounded;
  endproperty
  a_grounded: assert property (p_grounded) // R11
    else $error("outputs not grounded with display off");

  sequence s_rel;
    !rst_n_int ##1 rst_n_int;
  endsequence
  property p_after_release;
    @(posedge sys_clk) s_rel |-> s_q.st == LRC_ST_RESET && !init_seen;
  endproperty
  a_after_release: assert property (p_after_release) // R6
    else $error("not in power-on state after release");

  // first cycle out of reset shows the full reset state
  property p_release_state;
    @(posedge sys_clk) s_rel |-> outputs_grounded && !cfg.display_en &&
      cfg.mux == LRC_MUX_8 && cfg.bias == LRC_BIAS_RST &&
      cfg.aux_out_cfg == 12'h000 && cfg.aux_static_level == 6'h00;
  endproperty
  a_release_state: assert property (p_release_state) // R11
    else $error("reset state wrong at release");

  // the reset state takes no command yet
  property p_reset_idle;
    @(posedge sys_clk) disable iff (!rst_n_int)
      s_q.st == LRC_ST_RESET |=> $stable(cfg);
  endproperty
  a_reset_idle: assert property (p_reset_idle) // R6
    else $error("command taken in reset state");

  property p_seg_count;
    @(posedge sys_clk) disable iff (!rst_n_int)
      clk_en && cfg.aux_out_cfg == 12'h000 && cfg.mux == LRC_MUX_4
      |=> seg_count == 6'h2C;
  endproperty
  a_seg_count: assert property (p_seg_count) // R9
    else $error("segment count wrong without aux");

  property p_seg_aux;
    @(posedge sys_clk) disable iff (!rst_n_int)
      clk_en && aux_used == LRC_AUX_PINS && cfg.mux == LRC_MUX_8
      |=> seg_count == 6'h22;
  endproperty
  a_seg_aux: assert property (p_seg_aux) // R10
    else $error("segment count wrong with six aux");

  property p_seg_max;
    @(posedge sys_clk) disable iff (!rst_n_int) seg_count <= 6'h2C;
  endproperty
  a_seg_max: assert property (p_seg_max) // R8
    else $error("more than 44 segments");

  property p_ram_keep;
    @(posedge sys_clk) disable iff (!rst_n_int)
      !ram_we && !cmd.valid ##1 !ram_we |->
      // case equality: unwritten words are random after power-on
      ram_q[cfg.seg_ram_ptr] === $past(ram_q[cfg.seg_ram_ptr]);
  endproperty
  a_ram_keep: assert property (p_ram_keep) // R5
    else $error("ram changed without write");

  property p_sync_release;
    @(posedge sys_clk) $rose(rst_n_int) |-> $past(rsync_q[0]);
  endproperty
  a_sync_release: assert property (p_sync_release) // R13
    else $error("reset release not synchronised");

  // pin held low for two edges: internal reset must already be low
  sequence s_pin_low;
    !resetn ##1 !resetn;
  endsequence
  property p_async_assert;
    @(posedge sys_clk) s_pin_low |-> !rst_n_int;
  endproperty
  a_async_assert: assert property (p_async_assert) // R13
    else $error("internal reset not asserted by pin");

  // reserved backplane code is never stored
  property p_mux_legal;
    @(posedge sys_clk) disable iff (!rst_n_int) cfg.mux != 2'h3;
  endproperty
  a_mux_legal: assert property (p_mux_legal) // R8
    else $error("illegal backplane code stored");

  // pointer past the last 1:8 segment is marked unusable
  property p_ptr_range;
    @(posedge sys_clk) disable iff (!rst_n_int)
      clk_en && cmd.valid && cmd.sel == LRC_CMD_SEG_PTR &&
      s_q.st != LRC_ST_RESET && cfg.mux == LRC_MUX_8 &&
      cmd.data[5:0] >= LRC_SEG_8 |=> !cfg.seg_ptr_ok;
  endproperty
  a_ptr_range: assert property (p_ptr_range) // R9
    else $error("out-of-range pointer accepted");

  // writes in 1:8 mode wrap the pointer after the last segment
  property p_ptr_wrap;
    @(posedge sys_clk) disable iff (!rst_n_int)
      ram_we && cfg.mux == LRC_MUX_8 && cfg.seg_ram_ptr == LRC_SEG_8 - 6'h01
      |=> cfg.seg_ram_ptr == 6'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) // R9
    else $error("pointer did not wrap at last segment");
endmodule // lrc_top

// File: dv/lrc_host_model.sv
/*
  host controller model: issues decoded commands to the config block.
  assumes one command every second sys_clk edge, whatever clk_en is, valid for one edge.
*/
`timescale 1ns/10ps
module lrc_host_model
  import lrc_pkg::*;
(
  input wire logic sys_clk, // oscillator clock
  output lrc_pkg::lrc_cmd_t cmd // decoded command to the block
);
  // idle bus from time zero
  initial cmd = '0;

  // one command, launched after an edge, taken at the next one
  task automatic send(input logic [3:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    cmd <= '{sel: s, data: d, valid: 1'b1};
    @(posedge sys_clk);
    cmd.valid <= 1'b0;
  endtask

  // start-up order: init first, modes, 40 ram words, then display on
  task automatic bring_up();
    send(LRC_CMD_INIT, 8'h00);
    send(LRC_CMD_BP_CNT, {6'h00, LRC_MUX_8});
    send(LRC_CMD_SEG_PTR, 8'h00);
    // words 0 to 39 get a known pattern before the display lights
    for (int i = 0; i < 40; i++)
      send(LRC_CMD_RAM_WR, 8'hC0 ^ 8'(i));
    send(LRC_CMD_MODE, 8'h01);
  endtask
endmodule // lrc_host_model

// File: dv/tb.sv
/*
  self-checking bench for the lcd driver reset/config block.
  assumes the host model drives cmd; bench owns reset and clock enable.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("BAD %s exp=%0h got=%0h", nm, exp, got); \
    end \
  end
module tb;
  import lrc_pkg::*;
  logic sys_clk = 1'b0; // 100 MHz clock
  logic resetn = 1'b0; // reset pin, active low
  logic clk_en = 1'b1; // run enable
  lrc_cmd_t cmd; // from host model
  lrc_cfg_t cfg; // live configuration
  lrc_cfg_t cfg_rst; // expected reset configuration
  logic [5:0] seg_count; // usable segments
  logic [7:0] ram_rd_data; // ram word at pointer
  logic init_seen; // init flag
  logic outputs_grounded; // pins at ground
  int mismatches = 0; // failed compares
  int samples_checked = 0; // all compares

  // free-running clock, 10 ns period
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  lrc_top dut_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .cmd(cmd),
    .cfg(cfg),
    .seg_count(seg_count),
    .ram_rd_data(ram_rd_data),
    .init_seen(init_seen),
    .outputs_grounded(outputs_grounded)
  );

  lrc_host_model host_u (
    .sys_clk(sys_clk),
    .cmd(cmd)
  );

  // verdict and end of run
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // let n edges pass, then sample off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // pin reset mid-run; cfg must fall before any clock edge
  task automatic pin_reset();
    @(posedge sys_clk);
    resetn <= 1'b0;
    #2;
    `CHK("cfg_async", cfg_rst, cfg)
    repeat (3) @(posedge sys_clk);
    `CHK("grounded", 1'b1, outputs_grounded)
    `CHK("seg_rst", 6'h28, seg_count)
    `CHK("init_rst", 1'b0, init_seen)
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // defaults after the first release
  task automatic t_defaults();
    settle(1);
    `CHK("cfg_por", cfg_rst, cfg)
    `CHK("seg_por", 6'h28, seg_count)
  endtask

  // full start-up, then ram must survive a pin reset
  task automatic t_ram_keep();
    host_u.bring_up();
    settle(2);
    `CHK("init", 1'b1, init_seen)
    `CHK("lit", 1'b0, outputs_grounded)
    host_u.send(LRC_CMD_SEG_PTR, 8'h05);
    settle(2);
    `CHK("ram5", 8'hC5, ram_rd_data)
    pin_reset();
    settle(1);
    `CHK("ram0_kept", 8'hC0, ram_rd_data)
    host_u.send(LRC_CMD_INIT, 8'h00);
    host_u.send(LRC_CMD_SEG_PTR, 8'h05);
    settle(2);
    `CHK("ram5_kept", 8'hC5, ram_rd_data)
    `CHK("init_again", 1'b1, init_seen)
  endtask

  // segment counts per backplane mode, with and without aux pins
  task automatic t_segments();
    logic [1:0] code [3];
    logic [5:0] plain [3];
    logic [5:0] aux [3];
    code = '{LRC_MUX_8, LRC_MUX_6, LRC_MUX_4};
    plain = '{6'h28, 6'h2A, 6'h2C};
    aux = '{6'h22, 6'h24, 6'h26};
    // pointer past the last 1:8 segment blocks ram writes
    host_u.send(LRC_CMD_SEG_PTR, 8'h28);
    host_u.send(LRC_CMD_RAM_WR, 8'h5A);
    settle(2);
    `CHK("ptr_bad", 1'b0, cfg.seg_ptr_ok)
    `CHK("ptr_held", 6'h28, cfg.seg_ram_ptr)
    for (int i = 0; i < 3; i++)
    begin
      host_u.send(LRC_CMD_BP_CNT, {6'h00, code[i]});
      settle(2);
      `CHK("seg_plain", plain[i], seg_count)
    end
    // reserved mode code must leave the 1:4 setting alone
    host_u.send(LRC_CMD_BP_CNT, 8'h03);
    settle(2);
    `CHK("mux_hold", LRC_MUX_4, cfg.mux)
    for (int g = 0; g < 3; g++)
      host_u.send(LRC_CMD_AUX_CFG, {2'b00, 2'(g), 4'h5});
    for (int i = 0; i < 3; i++)
    begin
      host_u.send(LRC_CMD_BP_CNT, {6'h00, code[i]});
      settle(2);
      `CHK("seg_aux", aux[i], seg_count)
    end
  endtask

  // frozen enable drops a command; then dividers return on reset
  task automatic t_freeze_rates();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    host_u.send(LRC_CMD_MODE, 8'h01);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    settle(2);
    `CHK("frozen", 1'b0, cfg.display_en)
    host_u.send(LRC_CMD_LCD_RATE, 8'h05);
    host_u.send(LRC_CMD_BL_RATE, 8'h03);
    host_u.send(LRC_CMD_MODE, 8'h0F);
    settle(2);
    `CHK("lcd_div", 5'h05, cfg.lcd_rate_div)
    `CHK("pd", 1'b1, cfg.power_down)
    `CHK("bl_div", 4'h3, cfg.backlight_rate_div)
    `CHK("pd_ground", 1'b1, outputs_grounded)
    pin_reset();
  endtask

  // hang guard
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    cfg_rst = '0;
    cfg_rst.lcd_rate_div = 5'h0E;
    cfg_rst.backlight_rate_div = 4'h7;
    cfg_rst.seg_ptr_ok = 1'b1;
    cfg_rst.bl_ptr_ok = 1'b1;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_defaults();
    t_ram_keep();
    t_segments();
    t_freeze_rates();
    tally_and_finish();
  end
endmodule // tb
